// *** shared/adc_seq_pkg.sv ***
// Package: register map, field positions and constants of the converter sequencer
package adc_seq_pkg;
    localparam logic [3:0] OFF_CTRL_ONE = 4'h0;
    localparam logic [3:0] OFF_CTRL_TWO = 4'h4;
    localparam logic [3:0] OFF_CTRL_THREE = 4'h8;
    localparam logic [3:0] OFF_SCAN_SEL = 4'hC;
    localparam logic [31:0] RESET_VALUE = 32'h0000_0000;
    // Control one
    localparam int B_ON = 15;
    localparam int B_STOP_IN_IDLE = 13;
    localparam int B_SSRC = 5;
    localparam int B_STOP_AFTER_FIRST_IRQ = 4;
    localparam int B_AUTO_SAMPLE_START = 2;
    localparam int B_SAMPLE_ENABLE = 1;
    localparam int B_DONE = 0;
    // Control two
    localparam int B_VCFG = 13;
    localparam int B_OFFSET_CALIBRATION_MODE = 12;
    localparam int B_SCAN = 10;
    localparam int B_BUFFER_FILL_HALF = 7;
    localparam int B_SMPI = 2;
    localparam int B_BUFFER_SPLIT_MODE = 1;
    localparam int B_ALTERNATE_SAMPLE_MODE = 0;
    // Control three
    localparam int B_CONVERSION_CLOCK_SOURCE = 15;
    localparam int B_SAMC = 8;
    localparam int B_ADCS = 0;
    // Scan select word: mask low, sample a select 19:16, sample b 27:24
    localparam int B_CHSA = 16;
    localparam int B_CHSB = 24;
    // Trigger codes
    localparam logic [2:0] TRIG_MANUAL = 3'h0;
    localparam logic [2:0] TRIG_EXT_EXTERNAL_INTERRUPT_ZERO = 3'h1;
    localparam logic [2:0] TRIG_TIMER = 3'h2;
    localparam logic [2:0] TRIG_CHARGE_TIME_UNIT = 3'h3;
    localparam logic [2:0] TRIG_AUTO = 3'h7;
    // Reference selections on ref_sel_o: bit1 high ext, bit0 low ext
    localparam logic [1:0] REF_SUPPLY = 2'h0;
    localparam logic [3:0] HALF_WORDS = 4'h8;
    localparam logic [3:0] LAST_WORD = 4'hF;
endpackage : adc_seq_pkg

// *** hdl/adc_sample_convert_sequencer.sv ***
// Sample/convert sequencer with Wishbone registers for a 10-bit converter
`timescale 1ns/1ps
module adc_sample_convert_sequencer (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [3:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic idle_i,
    input wire logic rc_tick_i,
    input wire logic timer_match_i,
    input wire logic ext_external_interrupt_zero_i,
    input wire logic charge_time_unit_event_i,
    input wire logic conv_done_i,
    input wire logic [9:0] conv_data_i,
    output logic sample_o,
    output logic conv_start_o,
    output logic tad_tick_o,
    output logic [3:0] input_sel_o,
    output logic offset_cal_o,
    output logic [1:0] ref_sel_o,
    output logic irq_o,
    output logic [3:0] buf_waddr_o,
    output logic [9:0] buf_wdata_o,
    output logic buf_we_o
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_SAMPLE = 3'b010,
        ST_CONVERT = 3'b100
    } state_t;

    state_t state;
    logic [31:0] ctrl_one, ctrl_two, ctrl_three, scan_sel;
    logic [7:0] div_cnt;
    logic [4:0] samc_cnt;
    logic [3:0] seq_cnt, wptr, scan_idx, next_scan;
    logic alt_b, ext_prev, buffer_fill_half, sample_enable, done, auto_sample_start;
    logic wr, rd_ack, running, trig_hit, start_conv, irq_now;
    logic sample_enable_wr_one, sample_enable_wr_zero, done_wr_zero;

    //////////////////////////////////////////////////////////////////////
    // Wishbone slave: registered answer with one wait state, ack one cycle after stb
    assign wr = cyc_i && stb_i && we_i && !ack_o;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= adc_seq_pkg::RESET_VALUE;
        end else if (cyc_i && stb_i && !ack_o) begin
            if (adr_i == adc_seq_pkg::OFF_CTRL_ONE) begin
                dat_o <= {ctrl_one[31:3], auto_sample_start, sample_enable, done};
            end else if (adr_i == adc_seq_pkg::OFF_CTRL_TWO) begin
                dat_o <= {ctrl_two[31:8], buffer_fill_half, ctrl_two[6:0]};
            end else if (adr_i == adc_seq_pkg::OFF_CTRL_THREE) begin
                dat_o <= ctrl_three;
            end else if (adr_i == adc_seq_pkg::OFF_SCAN_SEL) begin
                dat_o <= scan_sel;
            end else begin
                dat_o <= adc_seq_pkg::RESET_VALUE;
            end
        end
    end

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0] be,
                                          input logic [31:0] msk);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & msk;
        return (old & ~m) | (nw & m);
    endfunction : merge

    // Writable masks keep unimplemented bits at zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_one <= adc_seq_pkg::RESET_VALUE;
            ctrl_two <= adc_seq_pkg::RESET_VALUE;
            ctrl_three <= adc_seq_pkg::RESET_VALUE;
            scan_sel <= adc_seq_pkg::RESET_VALUE;
        end else if (wr) begin
            if (adr_i == adc_seq_pkg::OFF_CTRL_ONE) begin
                ctrl_one <= merge(ctrl_one, dat_i, sel_i, 32'h0000_A0F0);
            end else if (adr_i == adc_seq_pkg::OFF_CTRL_TWO) begin
                ctrl_two <= merge(ctrl_two, dat_i, sel_i, 32'h0000_F43F);
            end else if (adr_i == adc_seq_pkg::OFF_CTRL_THREE) begin
                ctrl_three <= merge(ctrl_three, dat_i, sel_i, 32'h0000_9FFF);
            end else if (adr_i == adc_seq_pkg::OFF_SCAN_SEL) begin
                scan_sel <= merge(scan_sel, dat_i, sel_i, 32'h0F0F_FFFF);
            end
        end
    end

    assign sample_enable_wr_one = wr && adr_i == adc_seq_pkg::OFF_CTRL_ONE
        && sel_i[0] && dat_i[adc_seq_pkg::B_SAMPLE_ENABLE];
    assign sample_enable_wr_zero = wr && adr_i == adc_seq_pkg::OFF_CTRL_ONE
        && sel_i[0] && !dat_i[adc_seq_pkg::B_SAMPLE_ENABLE];
    assign done_wr_zero = wr && adr_i == adc_seq_pkg::OFF_CTRL_ONE
        && sel_i[0] && !dat_i[adc_seq_pkg::B_DONE];

    //////////////////////////////////////////////////////////////////////
    // Conversion clock: bus clock divided, or RC tick
    logic [2:0] ssrc;
    logic [4:0] samc;
    logic [7:0] adcs;
    assign ssrc = ctrl_one[adc_seq_pkg::B_SSRC +: 3];
    assign samc = ctrl_three[adc_seq_pkg::B_SAMC +: 5];
    assign adcs = ctrl_three[adc_seq_pkg::B_ADCS +: 8];
    // Idle with stop-in-idle sends the sequencer to ST_IDLE and clears the clock divider, as does module off; registers stay writable
    assign running = ctrl_one[adc_seq_pkg::B_ON]
        && !(idle_i && ctrl_one[adc_seq_pkg::B_STOP_IN_IDLE]);

    logic half_tick;
    logic tad_phase;
    // Half period of 2*(N+1) bus clocks is N+1 clocks
    always_ff @(posedge clk_i) begin
        if (rst_i || !running) begin
            div_cnt <= 8'h00;
        end else if (div_cnt == adcs) begin
            div_cnt <= 8'h00;
        end else begin
            div_cnt <= div_cnt + 8'h01;
        end
    end
    assign half_tick = running && div_cnt == adcs;
    always_ff @(posedge clk_i) begin
        if (rst_i || !running) begin
            tad_phase <= 1'b0;
        end else if (half_tick) begin
            tad_phase <= !tad_phase;
        end
    end
    // RC source bypasses the divider entirely
    assign tad_tick_o = ctrl_three[adc_seq_pkg::B_CONVERSION_CLOCK_SOURCE]
        ? (running && rc_tick_i)
        : (half_tick && tad_phase);

    //////////////////////////////////////////////////////////////////////
    // Trigger selection
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ext_prev <= 1'b0;
        end else begin
            ext_prev <= ext_external_interrupt_zero_i;
        end
    end
    // Reserved codes 100..110 never trigger
    always_comb begin
        trig_hit = 1'b0;
        case (ssrc)
            adc_seq_pkg::TRIG_TIMER: trig_hit = timer_match_i;
            adc_seq_pkg::TRIG_EXT_EXTERNAL_INTERRUPT_ZERO: trig_hit = ext_external_interrupt_zero_i && !ext_prev;
            adc_seq_pkg::TRIG_CHARGE_TIME_UNIT: trig_hit = charge_time_unit_event_i;
            adc_seq_pkg::TRIG_AUTO:
                trig_hit = tad_tick_o && samc_cnt >= samc;
            adc_seq_pkg::TRIG_MANUAL: trig_hit = sample_enable_wr_zero;
            default: trig_hit = 1'b0;
        endcase
    end

    // Sample-time counter counts conversion clocks while sampling
    always_ff @(posedge clk_i) begin
        if (rst_i || state != ST_SAMPLE) begin
            samc_cnt <= 5'h00;
        end else if (tad_tick_o && samc_cnt != 5'h1F) begin
            samc_cnt <= samc_cnt + 5'h01;
        end
    end

    assign start_conv = running && state == ST_SAMPLE && trig_hit;
    assign conv_start_o = start_conv;
    assign sample_o = state == ST_SAMPLE;

    //////////////////////////////////////////////////////////////////////
    // Sequencer
    logic seq_end;
    assign seq_end = running && state == ST_CONVERT && conv_done_i;
    assign irq_now = seq_end
        && seq_cnt == ctrl_two[adc_seq_pkg::B_SMPI +: 4];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_IDLE;
        end else if (!running) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                // A sample enable written while off starts once enabled
                ST_IDLE: if (sample_enable_wr_one || sample_enable || auto_sample_start) state <= ST_SAMPLE;
                ST_SAMPLE: if (start_conv) state <= ST_CONVERT;
                ST_CONVERT: if (conv_done_i) begin
                    // Auto start only survives if not cleared by this irq
                    if (auto_sample_start && !(irq_now && ctrl_one[adc_seq_pkg::B_STOP_AFTER_FIRST_IRQ])) begin
                        state <= ST_SAMPLE;
                    end else begin
                        state <= ST_IDLE;
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            auto_sample_start <= 1'b0;
        end else if (irq_now && ctrl_one[adc_seq_pkg::B_STOP_AFTER_FIRST_IRQ]) begin
            auto_sample_start <= 1'b0;
        end else if (wr && adr_i == adc_seq_pkg::OFF_CTRL_ONE && sel_i[0]) begin
            auto_sample_start <= dat_i[adc_seq_pkg::B_AUTO_SAMPLE_START];
        end
    end

    // Sample enable mirrors the sampling phase
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sample_enable <= 1'b0;
        end else if (start_conv) begin
            sample_enable <= 1'b0;
        end else if (state == ST_IDLE && running && (sample_enable_wr_one || auto_sample_start)) begin
            sample_enable <= 1'b1;
        end else if (seq_end && state == ST_CONVERT
                     && auto_sample_start && !(irq_now && ctrl_one[adc_seq_pkg::B_STOP_AFTER_FIRST_IRQ])) begin
            sample_enable <= 1'b1;
        end else if (sample_enable_wr_one) begin
            sample_enable <= 1'b1;
        end
    end

    // Set wins over a same-cycle software clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            done <= 1'b0;
        end else if (seq_end) begin
            done <= 1'b1;
        end else if (start_conv) begin
            done <= 1'b0;
        end else if (done_wr_zero) begin
            done <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_cnt <= 4'h0;
        end else if (irq_now) begin
            seq_cnt <= 4'h0;
        end else if (seq_end) begin
            seq_cnt <= seq_cnt + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= irq_now;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Result buffer addressing
    logic split;
    assign split = ctrl_two[adc_seq_pkg::B_BUFFER_SPLIT_MODE];
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wptr <= 4'h0;
            buffer_fill_half <= 1'b0;
        end else if (irq_now) begin
            wptr <= 4'h0;
            buffer_fill_half <= split ? !buffer_fill_half : 1'b0;
        end else if (seq_end) begin
            // Split halves wrap within eight words
            wptr <= (split && wptr == adc_seq_pkg::HALF_WORDS - 4'h1)
                ? 4'h0 : wptr + 4'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_we_o <= 1'b0;
            buf_waddr_o <= 4'h0;
            buf_wdata_o <= 10'h000;
        end else begin
            buf_we_o <= seq_end;
            buf_waddr_o <= split ? {buffer_fill_half, wptr[2:0]} : wptr;
            buf_wdata_o <= conv_data_i;
        end
    end

    //////////////////////////////////////////////////////////////////////
    // Input selection: scan, alternate, calibration
    always_comb begin
        next_scan = scan_idx;
        for (int k = 15; k >= 0; k--) begin
            if (scan_sel[4'(scan_idx + 4'(k + 1))]) begin
                next_scan = 4'(scan_idx + 4'(k + 1));
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            scan_idx <= 4'hF;
            alt_b <= 1'b0;
        end else if (irq_now || state == ST_IDLE) begin
            scan_idx <= adc_seq_pkg::LAST_WORD;
            alt_b <= 1'b0;
        end else if (start_conv) begin
            alt_b <= ctrl_two[adc_seq_pkg::B_ALTERNATE_SAMPLE_MODE] && !alt_b;
            if (ctrl_two[adc_seq_pkg::B_SCAN]) begin
                scan_idx <= next_scan;
            end
        end
    end

    logic [3:0] scan_now;
    assign scan_now = next_scan;
    assign input_sel_o = (ctrl_two[adc_seq_pkg::B_SCAN] && !alt_b)
        ? scan_now
        : alt_b ? scan_sel[adc_seq_pkg::B_CHSB +: 4]
        : scan_sel[adc_seq_pkg::B_CHSA +: 4];
    assign offset_cal_o = ctrl_two[adc_seq_pkg::B_OFFSET_CALIBRATION_MODE];

    always_comb begin
        case (ctrl_two[adc_seq_pkg::B_VCFG +: 3])
            3'h1: ref_sel_o = 2'h2;
            3'h2: ref_sel_o = 2'h1;
            3'h3: ref_sel_o = 2'h3;
            default: ref_sel_o = adc_seq_pkg::REF_SUPPLY;
        endcase
    end

    //////////////////////////////////////////////////////////////////////
    // Assertions
    property p_done_set;
        @(posedge clk_i) disable iff (rst_i) seq_end |=> done;
    endproperty
    a_done_set: assert property (p_done_set) else $error("done not set");

    property p_done_clr;
        @(posedge clk_i) disable iff (rst_i)
            start_conv && !seq_end |=> !done && state == ST_CONVERT;
    endproperty
    a_done_clr: assert property (p_done_clr) else $error("done kept");

    property p_sample_enable_clear;
        @(posedge clk_i) disable iff (rst_i) start_conv |=> !sample_enable;
    endproperty
    a_sample_enable_clear: assert property (p_sample_enable_clear) else $error("sample_enable kept");

    property p_stop_after_first_irq;
        @(posedge clk_i) disable iff (rst_i)
            irq_now && ctrl_one[adc_seq_pkg::B_STOP_AFTER_FIRST_IRQ] |=> !auto_sample_start ##0 irq_o;
    endproperty
    a_stop_after_first_irq: assert property (p_stop_after_first_irq) else $error("auto_sample_start kept");

    property p_no_reserved;
        @(posedge clk_i) disable iff (rst_i)
            ssrc[2] && ssrc != adc_seq_pkg::TRIG_AUTO |-> !start_conv;
    endproperty
    a_no_reserved: assert property (p_no_reserved) else $error("reserved trig");

    property p_auto_len;
        @(posedge clk_i) disable iff (rst_i)
            ssrc == adc_seq_pkg::TRIG_AUTO && start_conv |-> samc_cnt >= samc;
    endproperty
    a_auto_len: assert property (p_auto_len) else $error("short sample");

    property p_resample;
        @(posedge clk_i) disable iff (rst_i)
            seq_end && auto_sample_start && !irq_now |=> state == ST_SAMPLE && sample_enable;
    endproperty
    a_resample: assert property (p_resample) else $error("no resample");

    property p_ptr_reset;
        @(posedge clk_i) disable iff (rst_i) irq_now |=> wptr == 4'h0;
    endproperty
    a_ptr_reset: assert property (p_ptr_reset) else $error("ptr kept");
endmodule : adc_sample_convert_sequencer

// *** testbench/adc_core_model.sv ***
// Behavioural analog converter core
`timescale 1ns/1ps
module adc_core_model #(
    parameter int CONV_TADS = 12
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic conv_start_i,
    input wire logic tad_tick_i,
    output logic conv_done_o,
    output logic [9:0] conv_data_o
);
    int cnt;
    logic busy;
    logic [9:0] res;
    // Data toggles outside the done pulse so stale values never match
    always_ff @(posedge clk_i) begin
        conv_done_o <= 1'b0;
        conv_data_o <= ~conv_data_o;
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= 0;
            res <= 10'h0A5;
            conv_data_o <= 10'h000;
        end else if (conv_start_i) begin
            busy <= 1'b1;
            cnt <= 0;
        end else if (busy && tad_tick_i) begin
            cnt <= cnt + 1;
            if (cnt == CONV_TADS - 1) begin
                busy <= 1'b0;
                conv_done_o <= 1'b1;
                conv_data_o <= res;
                res <= res + 10'h03B;
            end
        end
    end
endmodule : adc_core_model

// *** testbench/adc_sample_convert_sequencer_tb.sv ***
// Self-checking bench for the sample/convert sequencer
`timescale 1ns/1ps
module adc_sample_convert_sequencer_tb;
    logic clk_i = 0, rst_i = 1, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [3:0] adr_i = 0, sel_i = 4'hF;
    logic [31:0] dat_i = 0, dat_o, q;
    logic ack_o, idle_i = 0, rc_tick_i = 0, timer_match_i = 0;
    logic ext_external_interrupt_zero_i = 0, charge_time_unit_event_i = 0, conv_done_i;
    logic [9:0] conv_data_i, buf_wdata_o, exp_data;
    logic sample_o, conv_start_o, tad_tick_o, offset_cal_o, irq_o;
    logic buf_we_o;
    logic [3:0] input_sel_o, buf_waddr_o;
    logic [1:0] ref_sel_o;
    int errors = 0, compares = 0, cycles = 0, rc_cnt = 0;
    int starts = 0, wes = 0, irqs = 0, slen = 0, n;
    logic [3:0] sels[$], addrs[$];
    int lens[$];
    adc_sample_convert_sequencer dut_u (.clk_i(clk_i), .rst_i(rst_i),
        .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
        .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .idle_i(idle_i), .rc_tick_i(rc_tick_i),
        .timer_match_i(timer_match_i), .ext_external_interrupt_zero_i(ext_external_interrupt_zero_i),
        .charge_time_unit_event_i(charge_time_unit_event_i), .conv_done_i(conv_done_i),
        .conv_data_i(conv_data_i), .sample_o(sample_o),
        .conv_start_o(conv_start_o), .tad_tick_o(tad_tick_o),
        .input_sel_o(input_sel_o), .offset_cal_o(offset_cal_o),
        .ref_sel_o(ref_sel_o), .irq_o(irq_o), .buf_waddr_o(buf_waddr_o),
        .buf_wdata_o(buf_wdata_o), .buf_we_o(buf_we_o));
    adc_core_model core_u (.clk_i(clk_i), .rst_i(rst_i),
        .conv_start_i(conv_start_o), .tad_tick_i(tad_tick_o),
        .conv_done_o(conv_done_i), .conv_data_o(conv_data_i));
    always #25 clk_i = ~clk_i;
    ////////////////////////////////////////////////////////////////////
    // RC clock stand-in, period of 7 bus clocks
    always @(posedge clk_i) begin
        rc_cnt <= (rc_cnt == 6) ? 0 : rc_cnt + 1;
        rc_tick_i <= (rc_cnt == 6);
    end
    // Counts events so short pulses are never missed between tasks
    always @(posedge clk_i) begin
        slen = (sample_o === 1'b1) ? slen + 1 : 0;
        if (conv_start_o === 1'b1) begin
            starts++;
            sels.push_back(input_sel_o);
            lens.push_back(slen);
        end
        if (buf_we_o === 1'b1) begin
            wes++;
            addrs.push_back(buf_waddr_o);
            check(buf_wdata_o, exp_data);
        end
        if (conv_done_i === 1'b1) exp_data = conv_data_i;
        if (irq_o === 1'b1) irqs++;
        cycles++;
        if (cycles == 30000) begin
            errors++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wb(input logic w, input logic [3:0] a,
                      input logic [31:0] d);
        @(posedge clk_i);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        do begin
            @(posedge clk_i);
        end while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
    endtask : wb
    // Bounded wait for buf_we_o (1) or tad_tick_o (2), edge count in n
    task automatic wait_on(input int w);
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while ((w == 1 ? buf_we_o : tad_tick_o) !== 1'b1 && n < 400);
        if (n >= 400) begin
            errors++;
            $display("Error at %0t: event wait ran out", $time);
        end
    endtask : wait_on
    task automatic pulse(input int w);
        @(posedge clk_i);
        ext_external_interrupt_zero_i <= (w == 1);
        timer_match_i <= (w == 2);
        charge_time_unit_event_i <= (w == 3);
        @(posedge clk_i);
        ext_external_interrupt_zero_i <= 1'b0;
        timer_match_i <= 1'b0;
        charge_time_unit_event_i <= 1'b0;
    endtask : pulse
    task automatic finish_test();
        $display("Counts: %0d compares, %0d errors", compares, errors);
        if (errors == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    ////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        logic [1:0] r;
        wb(0, 4'h0, 0);
        check(q, 32'h0000_0000);
        wb(0, 4'h2, 0);
        check(q, 32'h0000_0000);
        wb(1, 4'h8, 32'hFFFF_FFFF);
        wb(0, 4'h8, 0);
        check(q, 32'h0000_9FFF);
        wb(1, 4'h4, 32'hFFFF_FFFF);
        wb(0, 4'h4, 0);
        check(q, 32'h0000_F43F);
        for (int v = 0; v < 8; v++) begin
            wb(1, 4'h4, (v << 13) | ((v & 1) << 12));
            r = (v == 1) ? 2'b10 : (v == 2) ? 2'b01 : (v == 3) ? 2'b11 : 0;
            check(ref_sel_o, r);
            check(offset_cal_o, v & 1);
        end
        wb(1, 4'h4, 0);
        $display("t_regs done");
    endtask : t_regs
    task automatic t_clock();
        logic [31:0] c3[3] = '{32'h0000_0001, 32'h0000_0000, 32'h0000_8005};
        int gap[3] = '{4, 2, 7};
        int t;
        wb(1, 4'h0, 32'h0000_8000);
        for (int i = 0; i < 3; i++) begin
            wb(1, 4'h8, c3[i]);
            repeat (3) wait_on(2);
            check(n, gap[i]);
        end
        // Idle with stop-in-idle set must freeze the conversion clock
        wb(1, 4'h0, 32'h0000_A000);
        @(posedge clk_i);
        idle_i <= 1'b1;
        t = 0;
        repeat (20) begin
            @(posedge clk_i);
            t += tad_tick_o;
        end
        check(t, 0);
        idle_i <= 1'b0;
        wb(1, 4'h8, 0);
        $display("t_clock done");
    endtask : t_clock
    task automatic t_manual();
        int s0;
        s0 = starts;
        wb(1, 4'h0, 32'h0000_8002);
        repeat (3) @(posedge clk_i);
        check(sample_o, 1);
        check(starts, s0);
        wb(1, 4'h0, 32'h0000_8000);
        repeat (2) @(posedge clk_i);
        check(sample_o, 0);
        check(starts, s0 + 1);
        wait_on(1);
        wb(0, 4'h0, 0);
        check(q, 32'h0000_8001);
        wb(1, 4'h0, 32'h0000_8000);
        wb(0, 4'h0, 0);
        check(q, 32'h0000_8000);
        $display("t_manual done");
    endtask : t_manual
    task automatic t_trig(input int c);
        int s0;
        wb(1, 4'h0, 32'h0000_8002 | (c << 5));
        s0 = starts;
        pulse(c == 3 ? 1 : c + 1);
        repeat (2) @(posedge clk_i);
        check(starts, s0);
        pulse(c);
        repeat (2) @(posedge clk_i);
        check(starts, s0 + 1);
        wait_on(1);
        wb(0, 4'h0, 0);
        check(q, 32'h0000_8001 | (c << 5));
        wb(1, 4'h0, 0);
        $display("t_trig done");
    endtask : t_trig
    task automatic t_auto();
        int s0, w0, i0;
        sels.delete();
        addrs.delete();
        lens.delete();
        s0 = starts;
        w0 = wes;
        i0 = irqs;
        wb(1, 4'h8, 32'h0000_0200);
        wb(1, 4'h4, 32'h0000_0005);
        wb(1, 4'hC, 32'h0903_0000);
        wb(1, 4'h0, 32'h0000_80F4);
        repeat (300) @(posedge clk_i);
        check(starts - s0, 2);
        check(wes - w0, 2);
        check(irqs - i0, 1);
        check(sels[0], 4'h3);
        check(sels[1], 4'h9);
        check(addrs[0], 4'h0);
        check(addrs[1], 4'h1);
        check(lens[0] >= 4 && lens[0] <= 6, 1);
        check(lens[1] >= 4 && lens[1] <= 6, 1);
        wb(0, 4'h0, 0);
        check(q & 32'h0000_0005, 32'h0000_0001);
        $display("t_auto done");
    endtask : t_auto
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs();
        t_clock();
        t_manual();
        for (int c = 1; c < 4; c++) t_trig(c);
        t_auto();
        finish_test();
    end
endmodule : adc_sample_convert_sequencer_tb
